// ### dv/stack_mem_model.sv
// Purpose: data memory partner of the stack push/pop unit
// Assumes: one access open at a time, each ended by one ack pulse
// Notes: write log kept for the bench; read data moves outside acks
`timescale 1ns/1ps

module stack_mem_model (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [31:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] lat_in,
   input wire logic [7:0] err_at_in,
   output logic ack_out,
   output logic err_out,
   output logic [31:0] rdata_out
);
   logic [31:0] log_addr [0:15];
   logic [31:0] log_data [0:15];
   logic [7:0] n_acc;
   logic [3:0] wait_cnt;
   // -----------------------------------------
   // ack after lat cycle_count_low, error on access err_at
   // -----------------------------------------
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ack_out <= 1'b0;
         err_out <= 1'b0;
         rdata_out <= 32'h0000_0000;
         n_acc <= 8'h00;
         wait_cnt <= 4'h0;
      end else if (req_in && !ack_out && wait_cnt >= lat_in) begin
         ack_out <= 1'b1;
         err_out <= (n_acc + 8'h01 == err_at_in);
         rdata_out <= ~addr_in;
         n_acc <= n_acc + 8'h01;
         wait_cnt <= 4'h0;
         if (we_in) begin
            log_addr[n_acc[3:0]] <= addr_in;
            log_data[n_acc[3:0]] <= wdata_in;
         end
      end else begin
         ack_out <= 1'b0;
         err_out <= 1'b0;
         rdata_out <= rdata_out + 32'h0000_0001; // no stale word outside an ack
         if (req_in && !ack_out) begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule

// ### dv/test_stack_push_pop_unit.sv
// Purpose: self-checking bench of the stack push/pop unit
// Assumes: memory partner model, register file data from grp/idx
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`include "stack_regs.svh"

module test_stack_push_pop_unit;
   logic clk, rstn, valid, user, pload, ready, rf_we, mreq, mwe, excv, ien, idis, hold, done;
   logic ack, err;
   logic [15:0] instr;
   logic [31:0] pval, rf_rdata, mrdata, sp, rf_wdata, maddr, mwdata;
   logic [2:0] grp, idx, s_exc;
   stack_pkg::exc_e exc_code;
   logic [3:0] lat;
   logic [7:0] err_at, n0;
   logic s_en, s_dis, s_hold, s_wr, s_done;
   logic [31:0] s_rf;
   int mismatches, n_compared;
   assign rf_rdata = {16'hbeef, 10'h000, grp, idx};

   stack_push_pop_unit DUT (.sys_clk_in(clk), .rstn_in(rstn), .instr_valid_in(valid),
      .instr_in(instr), .user_mode_in(user), .ptr_load_in(pload), .ptr_load_value_in(pval),
      .rf_rdata_in(rf_rdata), .mem_ack_in(ack), .mem_err_in(err), .mem_rdata_in(mrdata),
      .instr_ready_out(ready), .stack_pointer_out(sp), .rf_grp_out(grp), .rf_idx_out(idx),
      .rf_we_out(rf_we), .rf_wdata_out(rf_wdata), .mem_req_out(mreq), .mem_we_out(mwe),
      .mem_addr_out(maddr), .mem_wdata_out(mwdata), .exc_valid_out(excv),
      .exc_code_out(exc_code), .int_enable_out(ien), .int_disable_out(idis),
      .irq_hold_out(hold), .done_out(done));
   stack_mem_model mem (.sys_clk_in(clk), .rstn_in(rstn), .req_in(mreq), .we_in(mwe),
      .addr_in(maddr), .wdata_in(mwdata), .lat_in(lat), .err_at_in(err_at), .ack_out(ack),
      .err_out(err), .rdata_out(mrdata));

   // -----------------------------------------
   // shared tasks
   // -----------------------------------------
   function automatic logic [15:0] enc(input logic [5:0] op, input logic [1:0] de,
                                       input logic [2:0] g, input logic [2:0] i);
      enc = {op, de, 2'b00, g, i};
   endfunction
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (e !== g) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic setsp(input logic [31:0] v);
      pload = 1'b1;
      pval = v;
      @(posedge clk);
      #1 pload = 1'b0;
   endtask
   // issue one word, watch pulses until done or exception
   task automatic run(input logic [15:0] w, input logic u);
      {s_en, s_dis, s_hold, s_wr, s_done, s_exc} = 0;
      n0 = mem.n_acc;
      instr = w;
      user = u;
      valid = 1'b1;
      @(posedge clk);
      #1 valid = 1'b0;
      for (int i = 0; i < 80 && !s_done && s_exc == 3'h0; i++) begin
         if (excv === 1'b1) s_exc = exc_code;
         if (ien === 1'b1) s_en = 1'b1;
         if (idis === 1'b1) s_dis = 1'b1;
         if (hold === 1'b1) s_hold = 1'b1;
         if (mreq === 1'b1 && mwe === 1'b1) s_wr = 1'b1;
         if (rf_we === 1'b1) s_rf = rf_wdata;
         if (done === 1'b1) s_done = 1'b1;
         @(posedge clk);
         #1;
      end
      chk("run end", 32'h1, {31'h0, s_done || s_exc != 3'h0});
   endtask

   // -----------------------------------------
   // scenarios
   // -----------------------------------------
   task automatic t_push_pop;
      lat = 4'h2;
      setsp(32'h0000_0100);
      run(enc(`STK_OPC_PUSH, 2'b00, 3'h0, 3'h3), 1'b0);
      chk("push sp", 32'h0000_00fc, sp);
      chk("push addr", 32'h0000_00fc, mem.log_addr[n0[3:0]]);
      chk("push data", 32'hbeef_0003, mem.log_data[n0[3:0]]);
      chk("push hold", 32'h0, {31'h0, s_hold});
      run(enc(`STK_OPC_POP, 2'b00, 3'h2, 3'h1), 1'b0);
      chk("pop data", ~32'h0000_00fc, s_rf);
      chk("pop sp", 32'h0000_0100, sp);
      chk("pop wrote", 32'h0, {31'h0, s_wr});
   endtask
   task automatic t_returns;
      lat = 4'h0;
      for (int k = 0; k < 4; k++) begin
         run(enc(k[0] ? `STK_OPC_POP : `STK_OPC_PUSH, 2'b00, 3'h5, k[1] ? 3'h1 : 3'h2), 1'b0);
         chk("int enable", {31'h0, !k[1] && !k[0]}, {31'h0, s_en});
         chk("int disable", {31'h0, !k[1] && k[0]}, {31'h0, s_dis});
      end
   endtask
   task automatic t_refused;
      run(enc(`STK_OPC_POP, 2'b00, 3'h1, 3'h7), 1'b0);
      chk("pop sp", stack_pkg::EXC_UNDEF, {29'h0, s_exc});
      run(enc(`STK_OPC_PUSH, 2'b00, 3'h5, 3'h7), 1'b1);
      chk("user push", stack_pkg::EXC_PROTECT, {29'h0, s_exc});
      run(enc(`STK_OPC_POP, 2'b00, 3'h7, 3'h1), 1'b1);
      chk("user pop", stack_pkg::EXC_PROTECT, {29'h0, s_exc});
      setsp(32'h0000_0102);
      run(enc(`STK_OPC_PUSH, 2'b00, 3'h0, 3'h0), 1'b0);
      chk("unaligned", stack_pkg::EXC_UNALIGNED, {29'h0, s_exc});
      chk("unaligned sp", 32'h0000_0102, sp);
      chk("refused ready", 32'h1, {31'h0, ready});
   endtask
   task automatic t_multi;
      lat = 4'h1;
      setsp(32'h0000_0200);
      run(enc(`STK_OPC_PUSHM, 2'b11, 3'h6, 3'h4), 1'b0);
      chk("hold", 32'h1, {31'h0, s_hold});
      chk("multi sp", 32'h0000_01f0, sp);
      for (int j = 0; j < 4; j++) begin
         chk("multi addr", 32'h0000_01fc - 4 * j, mem.log_addr[n0[3:0] + j]);
         chk("multi data", {16'hbeef, 10'h0, (j[1] ? 6'o14 : 6'o06) | 6'(j[0])},
             mem.log_data[n0[3:0] + j]);
      end
      setsp(32'h0000_0300);
      err_at = mem.n_acc + 8'h02;
      run(enc(`STK_OPC_PUSHM, 2'b10, 3'h5, 3'h0), 1'b0);
      err_at = 8'h00;
      chk("abort exc", stack_pkg::EXC_MEMORY, {29'h0, s_exc});
      chk("abort sp", 32'h0000_0300, sp);
      chk("kept data", 32'hbeef_0005, mem.log_data[n0[3:0]]);
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // clock, reset, main sequence and watchdog
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      {rstn, valid, user, pload, pval, instr, lat, err_at} = 0;
      repeat (16) @(posedge clk);
      #1 rstn = 1'b1;
      @(posedge clk);
      #1;
      t_push_pop();
      t_returns();
      t_refused();
      t_multi();
      results();
   end
   initial begin
      #100000;
      mismatches++;
      results();
   end
endmodule

// ### logic/stack_check.sv
// Purpose: pick the exception raised by a stack instruction at issue
// Assumes: decode outputs valid in the same cycle
// Notes: undefined beats protection beats alignment
`timescale 1ns/1ps

module stack_check (
   input wire stack_pkg::op_e op_in,
   input wire logic undef_in,
   input wire logic priv_in,
   input wire logic user_mode_in,
   input wire logic [1:0] ptr_low_in,
   output stack_pkg::exc_e exc_out
);
   // ----------------------------------------
   // exception priority
   // ----------------------------------------
   always_comb begin
      exc_out = stack_pkg::EXC_NONE;
      if (op_in == stack_pkg::OP_NONE || undef_in) begin
         exc_out = stack_pkg::EXC_UNDEF;
      end else if (priv_in && user_mode_in) begin
         exc_out = stack_pkg::EXC_PROTECT;
      end else if (ptr_low_in != 2'h0) begin
         exc_out = stack_pkg::EXC_UNALIGNED;
      end
   end
endmodule

// ### logic/stack_decode.sv
// Purpose: decode a 16-bit stack instruction word
// Assumes: word is stable while instr_valid is high
// Notes: purely combinational
`timescale 1ns/1ps
`include "stack_regs.svh"

module stack_decode (
   input wire logic [15:0] instr_in,
   output stack_pkg::op_e op_out,
   output logic [2:0] grp_out,
   output logic [2:0] idx_out,
   output logic data_en_out,
   output logic ptr_en_out,
   output logic undef_out,
   output logic priv_out
);
   // ----------------------------------------
   // field split and legality
   // ----------------------------------------
   always_comb begin
      op_out = stack_pkg::OP_NONE;
      grp_out = instr_in[5:3];
      idx_out = instr_in[2:0];
      data_en_out = instr_in[`STK_BIT_DATA_EN];
      ptr_en_out = instr_in[`STK_BIT_PTR_EN];
      undef_out = 1'b0;
      priv_out = 1'b0;
      case (instr_in[`STK_OPC_HI:`STK_OPC_LO])
         `STK_OPC_PUSH: begin
            op_out = stack_pkg::OP_PUSH;
            // full register set, minus the stack pointer and holes
            case (grp_out)
               `STK_GRP_PTR: undef_out = (idx_out == `STK_IDX_STACK);
               `STK_GRP_ACC: undef_out = (idx_out > `STK_ACC_LAST);
               `STK_GRP_MISC: undef_out = (idx_out > `STK_IDX_SYSTEM_CONFIG_REG);
               default: undef_out = 1'b0;
            endcase
         end
         `STK_OPC_POP: begin
            op_out = stack_pkg::OP_POP;
            case (grp_out)
               `STK_GRP_PTR: undef_out = (idx_out == `STK_IDX_STACK);
               `STK_GRP_ACC: undef_out = (idx_out > `STK_ACC_LAST);
               `STK_GRP_LOOP: undef_out = (idx_out >= `STK_IDX_CYC_LO);
               `STK_GRP_MISC: undef_out = (idx_out != `STK_IDX_SYSTEM_CONFIG_REG);
               default: undef_out = 1'b0;
            endcase
         end
         `STK_OPC_PUSHM: begin
            op_out = stack_pkg::OP_PUSHM;
            // range limits bounded to data 0..7, pointer 0..5
            undef_out = !(data_en_out || ptr_en_out) ||
                        (ptr_en_out && idx_out > `STK_PTR_TOP);
         end
         default: undef_out = 1'b0;
      endcase
      // supervisor-only registers on single push/pop
      if (op_out == stack_pkg::OP_PUSH || op_out == stack_pkg::OP_POP) begin
         priv_out = (grp_out == `STK_GRP_SYS && idx_out >= `STK_IDX_INTRET) ||
                    (grp_out == `STK_GRP_MISC && idx_out == `STK_IDX_SYSTEM_CONFIG_REG);
      end
   end
endmodule

// ### logic/stack_push_pop_unit.sv
// Purpose: sequence single push, single pop and multi-register push
// Assumes: register data one cycle after select; memory ack with error flag ends an access
// Notes: one instruction at a time; stack pointer lives here
`timescale 1ns/1ps
`include "stack_regs.svh"

module stack_push_pop_unit (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic instr_valid_in,
   input wire logic [15:0] instr_in,
   input wire logic user_mode_in,
   input wire logic ptr_load_in,
   input wire logic [31:0] ptr_load_value_in,
   input wire logic [31:0] rf_rdata_in,
   input wire logic mem_ack_in,
   input wire logic mem_err_in,
   input wire logic [31:0] mem_rdata_in,
   output logic instr_ready_out,
   output logic [31:0] stack_pointer_out,
   output logic [2:0] rf_grp_out,
   output logic [2:0] rf_idx_out,
   output logic rf_we_out,
   output logic [31:0] rf_wdata_out,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [31:0] mem_addr_out,
   output logic [31:0] mem_wdata_out,
   output logic exc_valid_out,
   output stack_pkg::exc_e exc_code_out,
   output logic int_enable_out,
   output logic int_disable_out,
   output logic irq_hold_out,
   output logic done_out
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   stack_pkg::state_e state;
   stack_pkg::op_e op;
   stack_pkg::op_e dec_op;
   stack_pkg::exc_e chk_exc;
   logic [2:0] dec_grp;
   logic [2:0] dec_idx;
   logic dec_data_en;
   logic dec_ptr_en;
   logic dec_undef;
   logic dec_priv;
   logic ptr_en;
   logic [31:0] stack_pointer;
   logic [31:0] saved_pointer;
   logic accept;
   logic ack_ok;
   logic ack_err;
   logic last_reg;
   logic is_int_ret;
   logic [2:0] instr_latch_plim;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // true when the selected register ends the multi push range
   function automatic logic range_end(input logic [2:0] grp, input logic [2:0] idx,
                                      input logic pen);
      if (grp == `STK_GRP_DATA) begin
         range_end = (idx == `STK_DATA_TOP) && !pen;
      end else begin
         range_end = (idx == `STK_PTR_TOP);
      end
   endfunction
   // stack word step with wrap kept to 32 bits
   function automatic logic [31:0] step(input logic [31:0] val, input logic down);
      step = down ? val - `STK_WORD_BYTES : val + `STK_WORD_BYTES;
   endfunction

   // ----------------------------------------
   // decode and checks
   // ----------------------------------------
   stack_decode decode_u (
      .instr_in(instr_in),
      .op_out(dec_op),
      .grp_out(dec_grp),
      .idx_out(dec_idx),
      .data_en_out(dec_data_en),
      .ptr_en_out(dec_ptr_en),
      .undef_out(dec_undef),
      .priv_out(dec_priv)
   );
   stack_check check_u (
      .op_in(dec_op),
      .undef_in(dec_undef),
      .priv_in(dec_priv),
      .user_mode_in(user_mode_in),
      .ptr_low_in(stack_pointer[1:0]),
      .exc_out(chk_exc)
   );
   // handshake terms
   assign accept = instr_valid_in && instr_ready_out;
   assign ack_ok = (state == stack_pkg::S_WAIT) && mem_ack_in && !mem_err_in;
   assign ack_err = (state == stack_pkg::S_WAIT) && mem_ack_in && mem_err_in;
   assign last_reg = (op != stack_pkg::OP_PUSHM) || range_end(rf_grp_out, rf_idx_out, ptr_en);
   assign is_int_ret = (rf_grp_out == `STK_GRP_SYS) && (rf_idx_out == `STK_IDX_INTRET);

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // one instruction in flight, issue port closed meanwhile
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= stack_pkg::S_IDLE;
         op <= stack_pkg::OP_NONE;
         ptr_en <= 1'b0;
         instr_ready_out <= 1'b1;
      end else begin
         case (state)
            stack_pkg::S_IDLE: begin
               if (accept && chk_exc == stack_pkg::EXC_NONE) begin
                  state <= stack_pkg::S_SELECT;
                  op <= dec_op;
                  ptr_en <= dec_ptr_en;
                  instr_ready_out <= 1'b0;
               end
            end
            stack_pkg::S_SELECT: state <= stack_pkg::S_ACCESS;
            stack_pkg::S_ACCESS: state <= stack_pkg::S_WAIT;
            stack_pkg::S_WAIT: begin
               if (ack_err || (ack_ok && last_reg)) begin
                  state <= stack_pkg::S_IDLE;
                  instr_ready_out <= 1'b1;
               end else if (ack_ok) begin
                  state <= stack_pkg::S_SELECT;
               end
            end
            default: state <= stack_pkg::S_IDLE;
         endcase
      end
   end

   // register select: first of range, then walk upward
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rf_grp_out <= `STK_GRP_DATA;
         rf_idx_out <= 3'h0;
      end else if (accept && dec_op == stack_pkg::OP_PUSHM) begin
         rf_grp_out <= dec_data_en ? `STK_GRP_DATA : `STK_GRP_PTR;
         rf_idx_out <= dec_data_en ? dec_grp : dec_idx;
      end else if (accept) begin
         rf_grp_out <= dec_grp;
         rf_idx_out <= dec_idx;
      end else if (ack_ok && !last_reg) begin
         if (rf_grp_out == `STK_GRP_DATA && rf_idx_out == `STK_DATA_TOP) begin
            rf_grp_out <= `STK_GRP_PTR;
            rf_idx_out <= 3'(instr_latch_plim);
         end else begin
            rf_idx_out <= rf_idx_out + 3'h1;
         end
      end
   end

   // pointer lower limit kept for the second group
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         instr_latch_plim <= 3'h0;
      end else if (accept) begin
         instr_latch_plim <= instr_in[2:0] > `STK_PTR_TOP ? `STK_PTR_TOP : instr_in[2:0];
      end
   end

   // ----------------------------------------
   // stack pointer
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stack_pointer <= `STK_PTR_RESET;
         saved_pointer <= `STK_PTR_RESET;
      end else begin
         if (accept) saved_pointer <= stack_pointer; // snapshot for abort restore
         if (ptr_load_in && state == stack_pkg::S_IDLE && !accept) begin
            stack_pointer <= ptr_load_value_in;
         end else if (state == stack_pkg::S_ACCESS && op != stack_pkg::OP_POP) begin
            stack_pointer <= step(stack_pointer, 1'b1);
         end else if (ack_ok && op == stack_pkg::OP_POP) begin
            stack_pointer <= step(stack_pointer, 1'b0);
         end else if (ack_err) begin
            stack_pointer <= saved_pointer;
         end
      end
   end

   // the pointer flop itself drives the port
   assign stack_pointer_out = stack_pointer;

   // ----------------------------------------
   // memory port
   // ----------------------------------------
   // one access at a time, held until acknowledged
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
         mem_addr_out <= 32'h0000_0000;
         mem_wdata_out <= 32'h0000_0000;
      end else if (state == stack_pkg::S_ACCESS) begin
         mem_req_out <= 1'b1;
         if (op == stack_pkg::OP_POP) begin
            mem_we_out <= 1'b0;
            mem_addr_out <= stack_pointer;
         end else begin
            mem_we_out <= 1'b1;
            mem_addr_out <= step(stack_pointer, 1'b1);
            mem_wdata_out <= rf_rdata_in;
         end
      end else if (state == stack_pkg::S_WAIT && mem_ack_in) begin
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // register file write-back
   // ----------------------------------------
   // popped value loads the register; flags only change via arith status
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rf_we_out <= 1'b0;
         rf_wdata_out <= 32'h0000_0000;
      end else begin
         rf_we_out <= ack_ok && op == stack_pkg::OP_POP;
         if (ack_ok && op == stack_pkg::OP_POP) begin
            rf_wdata_out <= mem_rdata_in;
         end
      end
   end

   // ----------------------------------------
   // interrupt side effects and hold-off
   // ----------------------------------------
   // only the interrupt return register touches the interrupt system
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         int_enable_out <= 1'b0;
         int_disable_out <= 1'b0;
      end else begin
         int_enable_out <= ack_ok && op == stack_pkg::OP_PUSH && is_int_ret;
         int_disable_out <= ack_ok && op == stack_pkg::OP_POP && is_int_ret;
      end
   end

   // hold new interrupts from first multi store until the last completes
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_hold_out <= 1'b0;
      end else if (state == stack_pkg::S_ACCESS && op == stack_pkg::OP_PUSHM) begin
         irq_hold_out <= 1'b1;
      end else if (ack_err || (ack_ok && last_reg)) begin
         irq_hold_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // completion and exceptions
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         exc_valid_out <= 1'b0;
         exc_code_out <= stack_pkg::EXC_NONE;
         done_out <= 1'b0;
      end else begin
         done_out <= ack_ok && last_reg;
         exc_valid_out <= (accept && chk_exc != stack_pkg::EXC_NONE) || ack_err;
         if (accept && chk_exc != stack_pkg::EXC_NONE) begin
            exc_code_out <= chk_exc;
         end else if (ack_err) begin
            exc_code_out <= stack_pkg::EXC_MEMORY;
         end else begin
            exc_code_out <= stack_pkg::EXC_NONE;
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   push_predec_a: assert property ((state == stack_pkg::S_ACCESS && op != stack_pkg::OP_POP)
      |=> mem_we_out && mem_addr_out == stack_pointer
          && stack_pointer == $past(stack_pointer) - `STK_WORD_BYTES)
      else $error("push address or predecrement wrong");
   pop_postinc_a: assert property ((ack_ok && op == stack_pkg::OP_POP)
      |=> rf_we_out && stack_pointer == $past(stack_pointer) + `STK_WORD_BYTES)
      else $error("pop load or postincrement wrong");
   pop_no_store_a: assert property ((op == stack_pkg::OP_POP && mem_req_out)
      |-> !mem_we_out)
      else $error("pop wrote memory");
   access_align_a: assert property (mem_req_out |-> mem_addr_out[1:0] == 2'h0)
      else $error("misaligned stack access issued");
   int_side_a: assert property (int_enable_out || int_disable_out
      |-> $past(is_int_ret) && !$past(op == stack_pkg::OP_PUSHM))
      else $error("interrupt side effect from wrong register");
   undef_pop_a: assert property ((accept && dec_op == stack_pkg::OP_POP
      && dec_grp == `STK_GRP_PTR && dec_idx == `STK_IDX_STACK)
      |=> exc_valid_out && exc_code_out == stack_pkg::EXC_UNDEF ##1 !mem_req_out)
      else $error("pop into stack pointer not rejected");
   user_protect_a: assert property ((accept && user_mode_in && dec_priv && !dec_undef)
      |=> exc_valid_out && exc_code_out == stack_pkg::EXC_PROTECT)
      else $error("protection violation missed");
   multi_hold_a: assert property ((state == stack_pkg::S_WAIT && op == stack_pkg::OP_PUSHM)
      |-> irq_hold_out)
      else $error("interrupt not held during multi push");
   abort_restore_a: assert property (ack_err
      |=> stack_pointer == $past(saved_pointer) && instr_ready_out)
      else $error("stack pointer not restored on abort");
   single_issue_a: assert property (state != stack_pkg::S_IDLE |-> !instr_ready_out)
      else $error("issue port open while busy");
endmodule

// ### shared/stack_pkg.sv
// Purpose: types of the stack push/pop unit
// Assumes: nothing
// Notes: constants live in stack_regs.svh
package stack_pkg;
   typedef enum logic [1:0] {OP_NONE, OP_PUSH, OP_POP, OP_PUSHM} op_e;
   typedef enum logic [2:0] {EXC_NONE, EXC_UNALIGNED, EXC_UNDEF, EXC_PROTECT,
                             EXC_MEMORY} exc_e;
   typedef enum logic [1:0] {S_IDLE, S_SELECT, S_ACCESS, S_WAIT} state_e;
endpackage

// ### shared/stack_regs.svh
// Purpose: constants of the stack push/pop unit
// Assumes: 16-bit stack instruction words, 32-bit stack words
// Notes: opcode and register-id layout is local to this core
`ifndef STACK_REGS_SVH
`define STACK_REGS_SVH

// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define STK_OPC_HI 15
`define STK_OPC_LO 10
`define STK_OPC_PUSH 6'h01
`define STK_OPC_POP 6'h02
`define STK_OPC_PUSHM 6'h03
`define STK_BIT_DATA_EN 9
`define STK_BIT_PTR_EN 8

// ----------------------------------------
// register groups and indices
// ----------------------------------------
`define STK_GRP_DATA 3'h0
`define STK_GRP_PTR 3'h1
`define STK_GRP_ACC 3'h4
`define STK_GRP_SYS 3'h5
`define STK_GRP_LOOP 3'h6
`define STK_GRP_MISC 3'h7
`define STK_IDX_FRAME 3'h6
`define STK_IDX_STACK 3'h7
`define STK_IDX_ARITH 3'h0
`define STK_IDX_SUBRET 3'h1
`define STK_IDX_INTRET 3'h2
`define STK_IDX_CYC_LO 3'h6
`define STK_IDX_EMUDATA 3'h0
`define STK_IDX_SYSTEM_CONFIG_REG 3'h1
`define STK_DATA_TOP 3'h7
`define STK_PTR_TOP 3'h5
`define STK_ACC_LAST 3'h3

// ----------------------------------------
// stack arithmetic and reset values
// ----------------------------------------
`define STK_WORD_BYTES 32'h0000_0004
`define STK_PTR_RESET 32'h0000_0000

`endif
